// >>> rtl/lbbp_top.sv
/*
 Blinking / breathing / general purpose LED modulator with watchdog.
 Assumes the system clock stands in for the fast clock, slow_tick is a
 one-cycle enable at the slow time base rate and wdt_tick at the
 watchdog rate, all synchronous to clock.
*/
`default_nettype none
module lbbp_top (
   input wire logic clock,
   input wire logic arst_n,
   input wire lbbp_pkg::lbbp_cfg_s cfg_in,
   input wire logic config_write,
   input wire logic [7:0] floor_in,
   input wire logic limits_write,
   input wire logic slow_tick,
   input wire logic wdt_tick,
   input wire logic pin_polarity,
   input wire logic sleep_request,
   output logic led_output_pin,
   output logic led_watchdog_timeout,
   output lbbp_pkg::lbbp_mode_e active_mode,
   output logic clock_request,
   output logic low_power_ok
);
   typedef logic [lbbp_pkg::PRESCALE_W-1:0] lbbp_pre_t;
   lbbp_pkg::lbbp_state_s s;
   lbbp_pkg::lbbp_state_s next_s;
   logic gp;
   logic tick;
   logic wrap;
   logic pre_done;
   logic reload;
   logic on_next;
   logic [7:0] top;
   logic [8:0] up_sum;
   logic [8:0] dn_dif;

   always_comb begin
      gp = s.cfg.mode == lbbp_pkg::LBBP_BLINK && s.cfg.fast_clk;
      tick = gp ? 1'b1 : slow_tick;
      case (s.cfg.period_size_select)
         lbbp_pkg::PERIOD_SIZE_SELECT_8: top = lbbp_pkg::MASK_8;
         lbbp_pkg::PERIOD_SIZE_SELECT_7: top = lbbp_pkg::MASK_7;
         default: top = lbbp_pkg::MASK_6;
      endcase
      // Blink span is 255 counts so FFh never drops out
      if (s.cfg.mode == lbbp_pkg::LBBP_BLINK) begin
         top = lbbp_pkg::BLINK_TOP;
      end
      wrap = s.period_ctr >= top;
      pre_done = s.pre_ctr >= s.cfg.prescale;
      reload = config_write || limits_write;
      up_sum = {1'b0, s.duty} + {1'b0, s.cfg.step};
      dn_dif = {1'b0, s.duty} - {1'b0, s.cfg.step};
   end

   always_comb begin
      next_s = s;
      next_s.irq = 1'b0;
      if (config_write) begin
         next_s.cfg = cfg_in;
      end
      if (limits_write) begin
         next_s.floor = floor_in;
      end
      if (reload) begin
         next_s.wdt_ctr = config_write ? cfg_in.wdt_reload
            : s.cfg.wdt_reload;
      end
      case (s.cfg.mode)
         lbbp_pkg::LBBP_BREATHE: begin
            if (slow_tick) begin
               next_s.period_ctr = wrap ? lbbp_pkg::ZERO8
                  : 8'(s.period_ctr + 8'h01);
               if (wrap && !pre_done) begin
                  next_s.pre_ctr = lbbp_pre_t'(s.pre_ctr + 12'h001);
               end
               if (wrap && pre_done) begin
                  next_s.pre_ctr = lbbp_pkg::PRE_ZERO;
                  case (s.phase)
                     lbbp_pkg::LBBP_UP: begin
                        if (up_sum >= {1'b0, s.cfg.ceiling}) begin
                           next_s.duty = s.cfg.ceiling;
                           next_s.phase = lbbp_pkg::LBBP_HOLD_HI;
                           next_s.hold_ctr = lbbp_pkg::ZERO8;
                        end else begin
                           next_s.duty = up_sum[7:0];
                        end
                     end
                     lbbp_pkg::LBBP_HOLD_HI: begin
                        if (s.hold_ctr >= s.cfg.hold_max) begin
                           next_s.phase = lbbp_pkg::LBBP_DOWN;
                           next_s.hold_ctr = lbbp_pkg::ZERO8;
                        end else begin
                           next_s.hold_ctr = 8'(s.hold_ctr + 8'h01);
                        end
                     end
                     lbbp_pkg::LBBP_DOWN: begin
                        if (dn_dif[8] || dn_dif[7:0] <= s.floor) begin
                           next_s.duty = s.floor;
                           next_s.phase = lbbp_pkg::LBBP_HOLD_LO;
                           next_s.hold_ctr = lbbp_pkg::ZERO8;
                        end else begin
                           next_s.duty = dn_dif[7:0];
                        end
                     end
                     lbbp_pkg::LBBP_HOLD_LO: begin
                        if (s.hold_ctr >= s.cfg.hold_min) begin
                           next_s.phase = lbbp_pkg::LBBP_UP;
                           next_s.hold_ctr = lbbp_pkg::ZERO8;
                        end else begin
                           next_s.hold_ctr = 8'(s.hold_ctr + 8'h01);
                        end
                     end
                     default: next_s.phase = lbbp_pkg::LBBP_UP;
                  endcase
               end
            end
         end
         lbbp_pkg::LBBP_BLINK: begin
            // Ramp state is parked; duty comes straight from floor
            next_s.duty = lbbp_pkg::ZERO8;
            next_s.phase = lbbp_pkg::LBBP_UP;
            if (tick && pre_done) begin
               next_s.pre_ctr = lbbp_pkg::PRE_ZERO;
               next_s.period_ctr = wrap ? lbbp_pkg::ZERO8
                  : 8'(s.period_ctr + 8'h01);
            end else if (tick) begin
               next_s.pre_ctr = lbbp_pre_t'(s.pre_ctr + 12'h001);
            end
         end
         default: begin
            // Off and on clear all ramp state
            next_s.period_ctr = lbbp_pkg::ZERO8;
            next_s.pre_ctr = lbbp_pkg::PRE_ZERO;
            next_s.duty = lbbp_pkg::ZERO8;
            next_s.phase = lbbp_pkg::LBBP_UP;
            next_s.hold_ctr = lbbp_pkg::ZERO8;
         end
      endcase
      // A write reload takes precedence over the decrement
      if (gp && wdt_tick && !reload && s.wdt_ctr != lbbp_pkg::ZERO8) begin
         next_s.wdt_ctr = 8'(s.wdt_ctr - 8'h01);
         if (s.wdt_ctr == lbbp_pkg::WDT_ONE) begin
            next_s.irq = 1'b1;
            // A same-cycle mode write reloads the count, so expiry cannot beat it
            next_s.cfg.mode = lbbp_pkg::LBBP_ON;
         end
      end
      case (next_s.cfg.mode)
         lbbp_pkg::LBBP_ON: on_next = 1'b1;
         lbbp_pkg::LBBP_BREATHE: on_next = next_s.period_ctr < next_s.duty;
         lbbp_pkg::LBBP_BLINK: on_next = next_s.period_ctr < next_s.floor;
         default: on_next = 1'b0;
      endcase
      next_s.pin = on_next ^ pin_polarity;
      next_s.clk_req = next_s.cfg.mode == lbbp_pkg::LBBP_BLINK
         && next_s.cfg.fast_clk;
      // Slow-base modes tolerate the fast clock stopping
      next_s.lp_ok = sleep_request && !next_s.clk_req;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s <= '{cfg: lbbp_pkg::CFG_RST, floor: lbbp_pkg::ZERO8,
            period_ctr: lbbp_pkg::ZERO8, pre_ctr: lbbp_pkg::PRE_ZERO,
            duty: lbbp_pkg::ZERO8, phase: lbbp_pkg::LBBP_UP,
            hold_ctr: lbbp_pkg::ZERO8, wdt_ctr: lbbp_pkg::WDT_RELOAD_RST,
            irq: 1'b0, pin: 1'b0, clk_req: 1'b0, lp_ok: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign led_output_pin = s.pin;
   assign led_watchdog_timeout = s.irq;
   assign active_mode = s.cfg.mode;
   assign clock_request = s.clk_req;
   assign low_power_ok = s.lp_ok;

   a_irq_one_cycle:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.irq |=> !s.irq) else $error("interrupt longer than one cycle");

   a_wdt_terminal_irq:
   assert property (@(posedge clock) disable iff (!arst_n)
      gp && wdt_tick && !reload && s.wdt_ctr == lbbp_pkg::WDT_ONE
      |=> s.irq && s.wdt_ctr == lbbp_pkg::ZERO8)
      else $error("watchdog terminal count missed");

   a_irq_forces_on:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.irq |-> s.cfg.mode == lbbp_pkg::LBBP_ON
      && $stable(s.cfg.prescale) && $stable(s.floor))
      else $error("watchdog expiry did not force on");

   a_off_pin_low:
   assert property (@(posedge clock) disable iff (!arst_n)
      // Reset forces the pin low whatever the polarity, so skip that edge
      $past(arst_n) && s.cfg.mode == lbbp_pkg::LBBP_OFF
      |-> s.pin == $past(pin_polarity))
      else $error("off mode pin wrong");

   a_on_pin_high:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.cfg.mode == lbbp_pkg::LBBP_ON |-> s.pin != $past(pin_polarity))
      else $error("on mode pin wrong");

   a_gp_clock_req:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.clk_req == (s.cfg.mode == lbbp_pkg::LBBP_BLINK && s.cfg.fast_clk))
      else $error("clock request mismatch");

   a_breathe_compare:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.cfg.mode == lbbp_pkg::LBBP_BREATHE
      |-> s.pin == ($past(pin_polarity) ^ (s.period_ctr < s.duty)))
      else $error("breathing compare wrong");

   a_blink_full_on:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.cfg.mode == lbbp_pkg::LBBP_BLINK && s.floor == lbbp_pkg::DUTY_FULL
      |-> s.pin != $past(pin_polarity)) else $error("FFh not full on");

   a_period_wrap_six:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.cfg.mode == lbbp_pkg::LBBP_BREATHE && !config_write && slow_tick
      && s.cfg.period_size_select == 2'h2 && s.period_ctr == lbbp_pkg::MASK_6
      |=> s.period_ctr == lbbp_pkg::ZERO8) else $error("6-bit wrap wrong");

   a_ceiling_hold:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.cfg.mode == lbbp_pkg::LBBP_BREATHE && !config_write
      && s.phase == lbbp_pkg::LBBP_HOLD_HI |=> $stable(s.duty))
      else $error("duty moved during hold");

   a_prescale_gate:
   assert property (@(posedge clock) disable iff (!arst_n)
      s.cfg.mode == lbbp_pkg::LBBP_BLINK && !config_write && !s.irq
      && s.pre_ctr < s.cfg.prescale |=> $stable(s.period_ctr))
      else $error("blink counter ran early");

   c_irq: cover property (@(posedge clock) disable iff (!arst_n) s.irq);
   c_hold_lo: cover property (@(posedge clock) disable iff (!arst_n)
      s.phase == lbbp_pkg::LBBP_HOLD_LO);
   c_gp_toggle: cover property (@(posedge clock) disable iff (!arst_n)
      gp && $rose(s.pin));
endmodule // lbbp_top
`default_nettype wire

// >>> rtl/lbbp_pkg.sv
/*
 Shared types and constants of the blinking and breathing LED modulator.
 Assumes one system clock; slow time base and watchdog ticks arrive as
 single-cycle enables synchronous to that clock.
*/
`default_nettype none
package lbbp_pkg;
   localparam int PRESCALE_W = 12;

   typedef enum logic [1:0] {
      LBBP_OFF = 2'b00,
      LBBP_BREATHE = 2'b01,
      LBBP_BLINK = 2'b10,
      LBBP_ON = 2'b11
   } lbbp_mode_e;

   typedef enum logic [1:0] {
      LBBP_UP = 2'b00,
      LBBP_HOLD_HI = 2'b01,
      LBBP_DOWN = 2'b10,
      LBBP_HOLD_LO = 2'b11
   } lbbp_phase_e;

   localparam logic [1:0] PERIOD_SIZE_SELECT_8 = 2'h0;
   localparam logic [1:0] PERIOD_SIZE_SELECT_7 = 2'h1;
   localparam logic [7:0] MASK_8 = 8'hFF;
   localparam logic [7:0] MASK_7 = 8'h7F;
   localparam logic [7:0] MASK_6 = 8'h3F;
   localparam logic [7:0] BLINK_TOP = 8'hFE;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] WDT_ONE = 8'h01;
   localparam logic [7:0] WDT_RELOAD_RST = 8'h14;
   localparam logic [PRESCALE_W-1:0] PRE_ZERO = 12'h000;

   typedef struct packed {
      lbbp_mode_e mode;
      logic fast_clk;
      logic [1:0] period_size_select;
      logic [PRESCALE_W-1:0] prescale;
      logic [7:0] hold_max;
      logic [7:0] hold_min;
      logic [7:0] ceiling;
      logic [7:0] step;
      logic [7:0] wdt_reload;
   } lbbp_cfg_s;

   localparam lbbp_cfg_s CFG_RST = '{mode: LBBP_OFF, fast_clk: 1'b0,
      period_size_select: PERIOD_SIZE_SELECT_8, prescale: PRE_ZERO, hold_max: ZERO8,
      hold_min: ZERO8, ceiling: ZERO8, step: ZERO8,
      wdt_reload: WDT_RELOAD_RST};

   typedef struct packed {
      lbbp_cfg_s cfg;
      logic [7:0] floor;
      logic [7:0] period_ctr;
      logic [PRESCALE_W-1:0] pre_ctr;
      logic [7:0] duty;
      lbbp_phase_e phase;
      logic [7:0] hold_ctr;
      logic [7:0] wdt_ctr;
      logic irq;
      logic pin;
      logic clk_req;
      logic lp_ok;
   } lbbp_state_s;
endpackage : lbbp_pkg
`default_nettype wire

// >>> tb/lbbp_led_load.sv
/*
 LED load on the modulator pin: counts the clock cycles it is lit.
 Assumes pin and clear are synchronous to the bench clock.
*/
`default_nettype none
module lbbp_led_load (
   input wire logic clock,
   input wire logic pin,
   input wire logic clear,
   output logic [15:0] lit_cycles
);
   timeunit 1ns;
   timeprecision 1ps;

   // Anode on the pin, so lit while the pin is high
   always_ff @(posedge clock) begin
      if (clear) begin
         lit_cycles <= 16'h0000;
      end else begin
         lit_cycles <= lit_cycles + {15'h0000, pin};
      end
   end
endmodule // lbbp_led_load
`default_nettype wire

// >>> tb/lbbp_tb_top.sv
/*
 Self-checking bench: mode table measured through the LED load, then
 watchdog, low power and mid-run reset cases.
 Assumes the system clock stands in for the fast clock.
*/
`default_nettype none
module lbbp_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [1:0] md;
      logic fst;
      logic [1:0] ps;
      logic [11:0] pre;
      logic [7:0] hmax;
      logic [7:0] flr;
      logic pol;
      logic [2:0] div;
      logic [15:0] win;
      logic [15:0] exp;
   } lbbp_row_s;

   localparam int NROWS = 15;
   // Windows hold whole periods, so the phase of the counter drops out
   localparam lbbp_row_s ROWS [NROWS] = '{
      '{2'h0,1'h0,2'h0,12'h000,8'h00,8'h80,1'h0,3'h1,16'h03FC,16'h0000},
      '{2'h0,1'h0,2'h0,12'h000,8'h00,8'h80,1'h1,3'h1,16'h03FC,16'h03FC},
      '{2'h3,1'h0,2'h0,12'h000,8'h00,8'h00,1'h0,3'h1,16'h03FC,16'h03FC},
      '{2'h3,1'h0,2'h0,12'h000,8'h00,8'h00,1'h1,3'h1,16'h03FC,16'h0000},
      '{2'h2,1'h1,2'h0,12'h000,8'h00,8'h00,1'h0,3'h1,16'h03FC,16'h0000},
      '{2'h2,1'h1,2'h0,12'h000,8'h00,8'hFF,1'h0,3'h1,16'h03FC,16'h03FC},
      '{2'h2,1'h1,2'h0,12'h000,8'h00,8'h40,1'h0,3'h1,16'h03FC,16'h0100},
      '{2'h2,1'h1,2'h0,12'h001,8'h00,8'h40,1'h0,3'h1,16'h03FC,16'h0100},
      '{2'h2,1'h1,2'h0,12'h000,8'h00,8'h40,1'h1,3'h1,16'h03FC,16'h02FC},
      '{2'h2,1'h0,2'h0,12'h000,8'h00,8'h40,1'h0,3'h4,16'h03FC,16'h0100},
      '{2'h2,1'h0,2'h0,12'h001,8'h00,8'h40,1'h0,3'h2,16'h03FC,16'h0100},
      '{2'h1,1'h0,2'h0,12'h000,8'h00,8'h00,1'h0,3'h1,16'h0200,16'h0000},
      '{2'h1,1'h0,2'h0,12'h000,8'hFF,8'h00,1'h0,3'h2,16'h0400,16'h0200},
      '{2'h1,1'h0,2'h1,12'h000,8'hFF,8'h00,1'h0,3'h1,16'h0200,16'h0200},
      '{2'h1,1'h0,2'h2,12'h000,8'hFF,8'h00,1'h0,3'h1,16'h0100,16'h0100}
   };

   logic clock = 1'b0;
   logic arst_n = 1'b0;
   lbbp_pkg::lbbp_cfg_s cfg_in = lbbp_pkg::CFG_RST;
   logic config_write = 1'b0;
   logic limits_write = 1'b0;
   logic [7:0] floor_in = 8'h00;
   logic slow_tick = 1'b0;
   logic wdt_tick = 1'b0;
   logic pin_polarity = 1'b0;
   logic sleep_request = 1'b1;
   logic led_clear = 1'b0;
   logic led_output_pin, led_watchdog_timeout, clock_request, low_power_ok;
   lbbp_pkg::lbbp_mode_e active_mode;
   logic [15:0] lit_cycles;
   logic [2:0] div = 3'h1;
   logic [2:0] tick_cnt = 3'h0;
   int irq_seen = 0;
   int fail_count = 0;
   int samples_checked = 0;

   always #10 clock = ~clock;

   // Slow time base as a tick every div cycles
   always @(posedge clock) begin
      tick_cnt <= (tick_cnt + 3'h1 >= div) ? 3'h0 : tick_cnt + 3'h1;
      slow_tick <= (tick_cnt == 3'h0);
      if (led_watchdog_timeout === 1'b1) begin
         irq_seen <= irq_seen + 1;
      end
   end

   lbbp_top i_lbbp_top (.clock(clock), .arst_n(arst_n), .cfg_in(cfg_in),
      .config_write(config_write), .floor_in(floor_in),
      .limits_write(limits_write), .slow_tick(slow_tick),
      .wdt_tick(wdt_tick), .pin_polarity(pin_polarity),
      .sleep_request(sleep_request), .led_output_pin(led_output_pin),
      .led_watchdog_timeout(led_watchdog_timeout),
      .active_mode(active_mode), .clock_request(clock_request),
      .low_power_ok(low_power_ok));

   lbbp_led_load i_lbbp_led_load (.clock(clock), .pin(led_output_pin),
      .clear(led_clear), .lit_cycles(lit_cycles));

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic do_reset();
      @(posedge clock);
      arst_n <= 1'b0;
      cycles(3);
      arst_n <= 1'b1;
   endtask

   task automatic apply(input lbbp_row_s r, input logic [7:0] wdt);
      lbbp_pkg::lbbp_cfg_s c;
      c = lbbp_pkg::CFG_RST;
      c.mode = lbbp_pkg::lbbp_mode_e'(r.md);
      c.fast_clk = r.fst;
      c.period_size_select = r.ps;
      c.prescale = r.pre;
      c.hold_max = r.hmax;
      c.hold_min = 8'hFF;
      c.ceiling = 8'h80;
      c.step = 8'h80;
      c.wdt_reload = wdt;
      cfg_in <= c;
      floor_in <= r.flr;
      pin_polarity <= r.pol;
      div <= r.div;
      config_write <= 1'b1;
      limits_write <= 1'b1;
      @(posedge clock);
      config_write <= 1'b0;
      limits_write <= 1'b0;
   endtask

   task automatic tick_wdt();
      @(posedge clock);
      wdt_tick <= 1'b1;
      @(posedge clock);
      wdt_tick <= 1'b0;
   endtask

   initial begin
      cycles(20);
      arst_n <= 1'b1;
      // Reset per row so breathing always starts at the ramp bottom
      for (int i = 0; i < NROWS; i++) begin
         do_reset();
         apply(ROWS[i], 8'h00);
         cycles(1200);
         led_clear <= 1'b1;
         @(posedge clock);
         led_clear <= 1'b0;
         cycles(int'(ROWS[i].win));
         #1;
         check(lit_cycles, ROWS[i].exp);
      end
      do_reset();
      apply(ROWS[6], 8'h02);
      cycles(4);
      #1;
      check({15'h0000, clock_request}, 16'h0001);
      check({15'h0000, low_power_ok}, 16'h0000);
      tick_wdt();
      cycles(10);
      #1;
      check(16'(irq_seen), 16'h0000);
      tick_wdt();
      cycles(10);
      #1;
      check(16'(irq_seen), 16'h0001);
      check({14'h0000, active_mode}, {14'h0000, lbbp_pkg::LBBP_ON});
      check({15'h0000, led_output_pin}, 16'h0001);
      check({15'h0000, low_power_ok}, 16'h0001);
      @(posedge clock);
      arst_n <= 1'b0;
      cycles(2);
      #1;
      check({14'h0000, active_mode}, 16'h0000);
      check({15'h0000, led_output_pin}, 16'h0000);
      check({15'h0000, clock_request}, 16'h0000);
      @(posedge clock);
      arst_n <= 1'b1;
      final_report();
   end

   // Run needs about 32000 cycles; cut off well past that
   initial begin
      #(20 * 60000);
      fail_count++;
      final_report();
   end
endmodule // lbbp_tb_top
`default_nettype wire
